//--- core/bisc_irq.sv
// Purpose: Sticky event status, mask and one level interrupt
// Assumes: Write strobes are one-cycle pulses from the bus slave
// Notes:   A new event in the clear cycle survives the clear
module bisc_irq (
   // Clock and reset
   input  wire logic                      core_clk_i,
   input  wire logic                      nrst_i,
   // Events and software access
   input  wire logic [bisc_pkg::EVT_W-1:0] evt_i,
   input  wire logic                      clr_we_i,
   input  wire logic                      mask_we_i,
   input  wire logic [bisc_pkg::EVT_W-1:0] wdata_i,
   // Results
   output logic [bisc_pkg::EVT_W-1:0]     status_o,
   output logic [bisc_pkg::EVT_W-1:0]     mask_o,
   output logic                           irq_o
);
   import bisc_pkg::*;

   typedef struct packed {
      logic [EVT_W-1:0] status;
      logic [EVT_W-1:0] mask;
      logic             irq;
   } bisc_irq_s;

   bisc_irq_s irq_reg;
   bisc_irq_s irq_next;

   always_comb begin
      irq_next = irq_reg;
      // Set beats clear
      irq_next.status = (irq_reg.status & ~(clr_we_i ? wdata_i : '0)) | evt_i;
      if (mask_we_i) begin
         irq_next.mask = wdata_i;
      end
      irq_next.irq = |(irq_next.status & irq_next.mask);
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         irq_reg <= '{status: '0, mask: IRQ_MASK_RST, irq: 1'b0};
      end else begin
         irq_reg <= irq_next;
      end
   end

   assign status_o = irq_reg.status;
   assign mask_o   = irq_reg.mask;
   assign irq_o    = irq_reg.irq;

endmodule // bisc_irq

//--- core/bisc_persist_timer.sv
// Purpose: Expires once its input level has been held for LIMIT cycles
// Assumes: LIMIT of at least one
// Notes:   Any drop of the input restarts the count from zero
module bisc_persist_timer #(
   parameter logic [31:0] LIMIT = 32'h1
) (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   // Level and result
   input  wire logic level_i,
   output logic      expired_o
);
   import bisc_pkg::*;

   typedef struct packed {
      logic [31:0] cnt;
      logic        expired;
   } bisc_tmr_s;

   bisc_tmr_s tmr_reg;
   bisc_tmr_s tmr_next;

   always_comb begin
      tmr_next = tmr_reg;
      if (!level_i) begin
         tmr_next.cnt     = 32'h0;      // R14
         tmr_next.expired = 1'b0;       // R14
      end else if (tmr_reg.cnt >= LIMIT - 32'h1) begin
         tmr_next.expired = 1'b1;
      end else begin
         tmr_next.cnt = tmr_reg.cnt + 32'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         tmr_reg <= '0;
      end else begin
         tmr_reg <= tmr_next;
      end
   end

   assign expired_o = tmr_reg.expired;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_restart;
      !level_i |=> tmr_reg.cnt == 32'h0 && !expired_o;
   endproperty
   a_restart: assert property (p_restart) else $error("timer did not restart"); // R14

endmodule // bisc_persist_timer

//--- core/bisc_pkg.sv
// Purpose: Shared constants and types for the battery isolator shutdown control
// Assumes: 40 MHz core clock; all timings held in seconds and converted here
// Notes:   Register offsets are byte addresses on a 32-bit APB slave
package bisc_pkg;

   localparam int unsigned CLK_HZ   = 40_000_000;

   // Timings in seconds
   localparam int unsigned MON_EN_S = 5;
   localparam int unsigned LV1_S    = 60;
   localparam int unsigned LV2_S    = 60;
   localparam int unsigned HOLD_S   = 10;

   // Cycle counts; the 60-second products exceed 2**31, so widen before multiplying
   localparam logic [31:0] MON_EN_CYC = 32'(64'(MON_EN_S) * 64'(CLK_HZ));
   localparam logic [31:0] LV1_CYC    = 32'(64'(LV1_S) * 64'(CLK_HZ));
   localparam logic [31:0] LV2_CYC    = 32'(64'(LV2_S) * 64'(CLK_HZ));
   localparam logic [31:0] HOLD_CYC   = 32'(64'(HOLD_S) * 64'(CLK_HZ));

   // Register map
   localparam logic [7:0] OFS_CTRL     = 8'h00;
   localparam logic [7:0] OFS_STATUS   = 8'h04;
   localparam logic [7:0] OFS_IRQ_STAT = 8'h08;
   localparam logic [7:0] OFS_IRQ_MASK = 8'h0c;

   // Control fields (write-only command pulses)
   localparam int unsigned CTRL_ON_BIT  = 0;
   localparam int unsigned CTRL_OFF_BIT = 1;

   // Interrupt events
   localparam int unsigned EVT_W       = 6;
   localparam int unsigned EV_OFF      = 0;
   localparam int unsigned EV_ESTOP    = 1;
   localparam int unsigned EV_LV1      = 2;
   localparam int unsigned EV_LV2      = 3;
   localparam int unsigned EV_HOLD_END = 4;
   localparam int unsigned EV_MON_EN   = 5;

   localparam logic [EVT_W-1:0] IRQ_MASK_RST = 6'h00;

   typedef enum logic [1:0] {
      BISC_OFF  = 2'b00,
      BISC_ON   = 2'b01,
      BISC_HOLD = 2'b11
   } bisc_state_e;

endpackage

//--- core/bisc_top.sv
// Purpose: Switch-on/off decisions, low-voltage trips and delayed
//          engine-controller supply hold for a battery isolation switch
// Assumes: All inputs synchronous to core_clk_i and already debounced
// Notes:   Registers over APB; one wait state on every transfer
//
// Contract
// R1: An off request from any switch wins over a simultaneous on request.
// R2: After switch-off, turn-on is refused while a remote switch reads on.
// R3: The remote input never closes the contacts, it only requests off.
// R4: Emergency input low opens the contacts and drops the hold at once.
// R5: Monitoring is enabled only after both buttons are held five seconds.
// R6: Monitoring enable is kept until power loss and starts disabled.
// R7: With monitoring on, one minute below the first threshold switches off.
// R8: An inhibit input tied to supply suppresses the monitored trip for good.
// R9: An inhibit input on ignition suppresses the monitored trip while high.
// R10: Sixty seconds below the second threshold always switches off.
// R11: After a normal switch-off the hold outputs stay on ten seconds.
// R12: Positive and negative hold outputs follow the same timing.
// R13: The test button drives a test request to the roll-over module.
// R14: Each low-voltage timer restarts when its indication clears early.
module bisc_top #(
   parameter logic [31:0] MON_EN_CYC = bisc_pkg::MON_EN_CYC,
   parameter logic [31:0] LV1_CYC    = bisc_pkg::LV1_CYC,
   parameter logic [31:0] LV2_CYC    = bisc_pkg::LV2_CYC,
   parameter logic [31:0] HOLD_CYC   = bisc_pkg::HOLD_CYC
) (
   // Clock and reset
   input  wire logic        core_clk_i,
   input  wire logic        nrst_i,
   // APB slave
   input  wire logic        psel_i,
   input  wire logic        penable_i,
   input  wire logic        pwrite_i,
   input  wire logic [7:0]  paddr_i,
   input  wire logic [31:0] pwdata_i,
   input  wire logic [3:0]  pstrb_i,
   output logic [31:0]      prdata_o,
   output logic             pready_o,
   output logic             pslverr_o,
   // Panel buttons
   input  wire logic        btn_on_i,
   input  wire logic        btn_off_i,
   input  wire logic        btn_test_i,
   // Remote switches and emergency input
   input  wire logic        ext_off_i,
   input  wire logic        ext_on_i,
   input  wire logic        estop_n_i,
   // Voltage comparators and monitoring inhibit
   input  wire logic        lv1_below_i,
   input  wire logic        lv2_below_i,
   input  wire logic        mon_inhibit_i,
   // Outputs to the switch, relays and roll-over module, and interrupt
   output logic             contacts_close_o,
   output logic             engine_controller_hold_output_pos_o,
   output logic             engine_controller_hold_output_neg_o,
   output logic             rollover_test_o,
   output logic             irq_o
);
   import bisc_pkg::*;

   typedef struct packed {
      bisc_state_e state;
      logic        contacts;
      logic        hold;
      logic        test;
      logic        mon_en;
      logic        btn_on_d;
      logic        sw_on;
      logic        sw_off;
      logic        pready;
      logic        pslverr;
      logic [31:0] prdata;
   } bisc_core_s;

   bisc_core_s core_reg;
   bisc_core_s core_next;

   logic             both_held;
   logic             mon_exp;
   logic             lv1_exp;
   logic             lv2_exp;
   logic             hold_exp;
   logic             acc;
   logic             wr_ok;
   logic             on_req;
   logic             man_off;
   logic             lv1_trip;
   logic             lv2_trip;
   logic             on_allowed;
   logic [EVT_W-1:0] evt;
   logic [EVT_W-1:0] irq_status;
   logic [EVT_W-1:0] irq_mask;
   logic             irq_w;

   function automatic logic addr_mapped(input logic [7:0] a);
      return a == OFS_CTRL || a == OFS_STATUS || a == OFS_IRQ_STAT || a == OFS_IRQ_MASK;
   endfunction

   function automatic logic feeds_hold(input bisc_state_e st);
      return st != BISC_OFF;
   endfunction

   // Timers
   assign both_held = btn_on_i & btn_off_i;

   bisc_persist_timer #(.LIMIT(MON_EN_CYC)) u_mon_tmr (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .level_i    (both_held),
      .expired_o  (mon_exp)
   );

   bisc_persist_timer #(.LIMIT(LV1_CYC)) u_lv1_tmr (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .level_i    (lv1_below_i),
      .expired_o  (lv1_exp)
   );

   bisc_persist_timer #(.LIMIT(LV2_CYC)) u_lv2_tmr (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .level_i    (lv2_below_i),
      .expired_o  (lv2_exp)
   );

   bisc_persist_timer #(.LIMIT(HOLD_CYC)) u_hold_tmr (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .level_i    (core_reg.state == BISC_HOLD),
      .expired_o  (hold_exp)
   );

   // Bus qualifiers: a write lands only on the edge that sees pready high
   assign acc   = psel_i & penable_i & core_reg.pready;
   assign wr_ok = acc & pwrite_i & pstrb_i[0];

   // Requests
   assign on_req     = (btn_on_i & ~core_reg.btn_on_d) | core_reg.sw_on; // R3
   assign man_off    = btn_off_i | ext_off_i | core_reg.sw_off;
   assign lv1_trip   = lv1_exp & core_reg.mon_en & ~mon_inhibit_i;      // R7 R8 R9
   assign lv2_trip   = lv2_exp;                                         // R10
   assign on_allowed = on_req & ~man_off & ~ext_on_i;                   // R1 R2

   always_comb begin
      core_next          = core_reg;
      core_next.btn_on_d = btn_on_i;
      core_next.sw_on    = 1'b0;
      core_next.sw_off   = 1'b0;
      core_next.test     = btn_test_i;                                   // R13
      core_next.mon_en   = core_reg.mon_en | mon_exp;                    // R5 R6

      // State
      if (!estop_n_i) begin
         core_next.state = BISC_OFF;                                     // R4
      end else begin
         case (core_reg.state)
            BISC_OFF: begin
               if (on_allowed) begin
                  core_next.state = BISC_ON;
               end
            end
            BISC_ON: begin
               if (man_off | lv1_trip | lv2_trip) begin
                  core_next.state = BISC_HOLD;                           // R1
               end
            end
            BISC_HOLD: begin
               if (hold_exp) begin
                  core_next.state = BISC_OFF;                            // R11
               end else if (on_allowed) begin
                  core_next.state = BISC_ON;                             // R2
               end
            end
            default: begin
               core_next.state = BISC_OFF;
            end
         endcase
      end
      core_next.contacts = core_next.state == BISC_ON;
      core_next.hold     = feeds_hold(core_next.state);                  // R11 R12

      // APB: one wait state, then data and pready together
      core_next.pready = psel_i & penable_i & ~core_reg.pready;
      if (core_next.pready) begin
         core_next.pslverr = ~addr_mapped(paddr_i);
         case (paddr_i)
            OFS_STATUS: begin
               core_next.prdata = {24'h0, lv2_exp, lv1_exp, mon_inhibit_i,
                                   core_reg.mon_en, core_reg.hold,
                                   core_reg.contacts, core_reg.state};
            end
            OFS_IRQ_STAT: begin
               core_next.prdata = {26'h0, irq_status};
            end
            OFS_IRQ_MASK: begin
               core_next.prdata = {26'h0, irq_mask};
            end
            default: begin
               core_next.prdata = 32'h0;
            end
         endcase
      end
      if (wr_ok && paddr_i == OFS_CTRL) begin
         core_next.sw_on  = pwdata_i[CTRL_ON_BIT];
         core_next.sw_off = pwdata_i[CTRL_OFF_BIT];
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         core_reg <= '0;
      end else begin
         core_reg <= core_next;
      end
   end

   // Events
   always_comb begin
      evt              = '0;
      evt[EV_OFF]      = core_reg.state == BISC_ON && core_next.state == BISC_HOLD;
      evt[EV_ESTOP]    = ~estop_n_i & (core_reg.state != BISC_OFF);
      evt[EV_LV1]      = lv1_trip & (core_reg.state == BISC_ON);
      evt[EV_LV2]      = lv2_trip & (core_reg.state == BISC_ON);
      evt[EV_HOLD_END] = hold_exp & estop_n_i & (core_reg.state == BISC_HOLD);
      evt[EV_MON_EN]   = mon_exp & ~core_reg.mon_en;
   end

   bisc_irq u_irq (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .evt_i      (evt),
      .clr_we_i   (wr_ok && paddr_i == OFS_IRQ_STAT),
      .mask_we_i  (wr_ok && paddr_i == OFS_IRQ_MASK),
      .wdata_i    (pwdata_i[EVT_W-1:0]),
      .status_o   (irq_status),
      .mask_o     (irq_mask),
      .irq_o      (irq_w)
   );

   assign prdata_o                            = core_reg.prdata;
   assign pready_o                            = core_reg.pready;
   assign pslverr_o                           = core_reg.pslverr;
   assign contacts_close_o                    = core_reg.contacts;
   assign engine_controller_hold_output_pos_o = core_reg.hold;
   assign engine_controller_hold_output_neg_o = core_reg.hold;
   assign rollover_test_o                     = core_reg.test;
   assign irq_o                               = irq_w;

   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   property p_off_wins;
      core_reg.state == BISC_ON && btn_off_i && btn_on_i |=> !contacts_close_o;
   endproperty
   a_off_wins: assert property (p_off_wins) else $error("off lost to on"); // R1

   property p_remote_on_blocks;
      !contacts_close_o && ext_on_i |=> !contacts_close_o;
   endproperty
   a_remote_on_blocks: assert property (p_remote_on_blocks) // R2
      else $error("closed with remote on");

   property p_close_cause;
      $rose(contacts_close_o) |-> $past(on_req) && $past(estop_n_i);
   endproperty
   a_close_cause: assert property (p_close_cause) else $error("close without on"); // R3

   property p_estop;
      !estop_n_i |=> !contacts_close_o && !engine_controller_hold_output_pos_o;
   endproperty
   a_estop: assert property (p_estop) else $error("emergency not immediate"); // R4

   property p_mon_enable;
      $rose(core_reg.mon_en) |-> $past(mon_exp) && $past(both_held, 2) && $past(both_held, 3);
   endproperty
   a_mon_enable: assert property (p_mon_enable) else $error("monitor enabled early"); // R5

   property p_mon_kept;
      core_reg.mon_en |=> core_reg.mon_en;
   endproperty
   a_mon_kept: assert property (p_mon_kept) else $error("monitor enable lost"); // R6

   property p_lv1_off;
      core_reg.state == BISC_ON && lv1_exp && core_reg.mon_en && !mon_inhibit_i
         |=> !contacts_close_o;
   endproperty
   a_lv1_off: assert property (p_lv1_off) else $error("no low-voltage trip"); // R7

   property p_inhibit;
      core_reg.state == BISC_ON && mon_inhibit_i && estop_n_i && !man_off && !lv2_exp
         |=> contacts_close_o;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("trip while inhibited"); // R8 R9

   property p_lv2_off;
      core_reg.state == BISC_ON && lv2_exp |=> !contacts_close_o;
   endproperty
   a_lv2_off: assert property (p_lv2_off) else $error("no second-threshold trip"); // R10

   sequence s_normal_off;
      contacts_close_o && estop_n_i ##1 !contacts_close_o;
   endsequence
   property p_hold_after_off;
      s_normal_off |-> engine_controller_hold_output_pos_o;
   endproperty
   a_hold_after_off: assert property (p_hold_after_off) else $error("hold missing"); // R11

   property p_hold_end;
      $fell(engine_controller_hold_output_pos_o) |-> $past(hold_exp) || !$past(estop_n_i);
   endproperty
   a_hold_end: assert property (p_hold_end) else $error("hold dropped early"); // R11

   property p_pair;
      engine_controller_hold_output_pos_o == engine_controller_hold_output_neg_o;
   endproperty
   a_pair: assert property (p_pair) else $error("hold outputs differ"); // R12

   property p_test;
      btn_test_i |=> rollover_test_o;
   endproperty
   a_test: assert property (p_test) else $error("test request missing"); // R13

endmodule // bisc_top

//--- testbench/bisc_far_model.sv
// Purpose: Far side model: remote switches and roll-over sensor module
// Assumes: Bench commands are levels, already debounced
// Notes:   A test request acts like a tilt, so it trips the switch too
module bisc_far_model (
   // Clock
   input  wire logic core_clk_i,
   // Bench commands
   input  wire logic tilt_i,
   input  wire logic remote_off_i,
   input  wire logic remote_on_i,
   // Device side
   input  wire logic test_req_i,
   output logic      estop_n_o,
   output logic      ext_off_o,
   output logic      ext_on_o
);
   timeunit 1ns;
   timeprecision 1ps;

   initial begin
      estop_n_o = 1'b1;
      ext_off_o = 1'b0;
      ext_on_o  = 1'b0;
   end

   // One cycle of latency, as a real sensor adds
   always @(posedge core_clk_i) begin
      estop_n_o <= !(tilt_i || test_req_i);
      ext_off_o <= remote_off_i;
      ext_on_o  <= remote_on_i;
   end
endmodule // bisc_far_model

//--- testbench/testbench.sv
// Purpose: Self-checking bench for the battery isolator shutdown control
// Assumes: Shortened timer parameters; far side from bisc_far_model
// Notes:   Random low-voltage blips stay below the trip count
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import bisc_pkg::*;
   localparam int MON_C = 8, LV1_C = 20, LV2_C = 24, HOLD_C = 16;
   logic        core_clk_i = 1'b0, nrst_i = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic        btn_on = 1'b0, btn_off = 1'b0, btn_test = 1'b0, lv1 = 1'b0, lv2 = 1'b0;
   logic        inhibit = 1'b0, tilt = 1'b0, r_off = 1'b0, r_on = 1'b0, err;
   logic        ext_off, ext_on, estop_n, contacts, hold_p, hold_n, test_req, irq;
   int          mismatches = 0, num_checks = 0, n;
   integer      seed;

   always #12.5 core_clk_i = ~core_clk_i;

   bisc_top #(.MON_EN_CYC(MON_C), .LV1_CYC(LV1_C), .LV2_CYC(LV2_C), .HOLD_CYC(HOLD_C))
   i_bisc_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
      .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(4'hf),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .btn_on_i(btn_on),
      .btn_off_i(btn_off), .btn_test_i(btn_test), .ext_off_i(ext_off), .ext_on_i(ext_on),
      .estop_n_i(estop_n), .lv1_below_i(lv1), .lv2_below_i(lv2), .mon_inhibit_i(inhibit),
      .contacts_close_o(contacts), .engine_controller_hold_output_pos_o(hold_p),
      .engine_controller_hold_output_neg_o(hold_n), .rollover_test_o(test_req), .irq_o(irq));

   bisc_far_model i_bisc_far_model (.core_clk_i(core_clk_i), .tilt_i(tilt),
      .remote_off_i(r_off), .remote_on_i(r_on), .test_req_i(test_req),
      .estop_n_o(estop_n), .ext_off_o(ext_off), .ext_on_o(ext_on));

   function automatic logic exp_irq(input logic [5:0] s, input logic [5:0] m);
      return |(s & m);
   endfunction

   task automatic stop_test;
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask

   task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
      num_checks++;
      if (g !== e) begin
         mismatches++;
         $display("MISMATCH %s expected %h seen %h", w, e, g);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge core_clk_i);
   endtask

   // Holds the request until pready is seen high at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int k;
      k = 0;
      @(posedge core_clk_i);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk_i);
      penable <= 1'b1;
      do begin
         @(posedge core_clk_i);
         k++;
      end while (pready !== 1'b1 && k < 50);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (k >= 50) begin
         mismatches++;
         $display("MISMATCH pready expected 1 seen %b", pready);
      end
   endtask

   task automatic pulse_on;
      tick(1);
      btn_on <= 1'b1;
      tick(1);
      btn_on <= 1'b0;
      tick(2);
   endtask

   initial begin
      #(25 * 6000);
      mismatches++;
      stop_test;
   end

   initial begin
      seed = 32'he49e;
      tick(16);
      nrst_i <= 1'b1;
      tick(2);
      chk("contacts", 0, contacts);
      apb(1'b0, OFS_STATUS, 32'h0);
      chk("mon_en", 0, rd[4]);
      pulse_on;
      chk("hold pair", 2'b11, {hold_p, hold_n});
      btn_off <= 1'b1;
      tick(1);
      btn_off <= 1'b0;
      tick(1);
      chk("contacts", 0, contacts);
      tick(HOLD_C - 1);
      chk("hold pair", 2'b11, {hold_p, hold_n});
      tick(2);
      chk("hold pair", 2'b00, {hold_p, hold_n});
      tick(1);
      r_off <= 1'b1;
      pulse_on;
      chk("contacts", 0, contacts);
      r_off <= 1'b0;
      r_on <= 1'b1;
      tick(3);
      chk("contacts", 0, contacts);
      pulse_on;
      chk("contacts", 0, contacts);
      r_on <= 1'b0;
      tick(2);
      pulse_on;
      chk("contacts", 1, contacts);
      tick(1);
      tilt <= 1'b1;
      tick(2);
      tilt <= 1'b0;
      tick(1);
      chk("outputs", 3'b000, {contacts, hold_p, hold_n});
      pulse_on;
      btn_test <= 1'b1;
      tick(1);
      btn_test <= 1'b0;
      tick(1);
      chk("test request", 1, test_req);
      tick(2);
      chk("outputs", 3'b000, {contacts, hold_p, hold_n});
      pulse_on;
      for (int i = 0; i < 3; i++) begin
         n = LV2_C - 2 - ($unsigned($random(seed)) % 4);
         tick(1);
         lv2 <= 1'b1;
         tick(n);
         lv2 <= 1'b0;
         chk("contacts", 1, contacts);
      end
      tick(1);
      lv2 <= 1'b1;
      tick(LV2_C + 4);
      lv2 <= 1'b0;
      chk("contacts", 0, contacts);
      pulse_on;
      lv1 <= 1'b1;
      tick(LV1_C + 6);
      chk("contacts", 1, contacts);
      lv1 <= 1'b0;
      for (int i = 0; i < 2; i++) begin
         tick(1);
         btn_on <= 1'b1;
         btn_off <= 1'b1;
         tick(i == 0 ? MON_C - 3 : MON_C + 3);
         btn_on <= 1'b0;
         btn_off <= 1'b0;
         apb(1'b0, OFS_STATUS, 32'h0);
         chk("mon_en", i, rd[4]);
      end
      inhibit <= 1'b1;
      pulse_on;
      lv1 <= 1'b1;
      tick(LV1_C + 6);
      chk("contacts", 1, contacts);
      inhibit <= 1'b0;
      tick(LV1_C + 6);
      chk("contacts", 0, contacts);
      lv1 <= 1'b0;
      tick(HOLD_C + 8);
      apb(1'b1, OFS_IRQ_MASK, 32'h3f);
      apb(1'b0, OFS_IRQ_MASK, 32'h0);
      chk("irq mask", 32'h3f, rd);
      apb(1'b0, OFS_IRQ_STAT, 32'h0);
      chk("irq status", 32'h3f, rd);
      chk("irq", exp_irq(6'h3f, 6'h3f), irq);
      apb(1'b1, OFS_IRQ_STAT, 32'h3f);
      apb(1'b1, OFS_IRQ_MASK, 32'h01);
      apb(1'b1, OFS_CTRL, 32'h1);
      tick(3);
      chk("contacts", 1, contacts);
      apb(1'b1, OFS_CTRL, 32'h2);
      tick(2);
      chk("contacts", 0, contacts);
      chk("irq", exp_irq(6'h01, 6'h01), irq);
      apb(1'b0, 8'h10, 32'h0);
      chk("slave error", 1, err);
      stop_test;
   end
endmodule // testbench
